// file: gsw_gpio_top.sv
// general-purpose port block with pin interrupts and suspend / wake.
// assumes a processor i/o space port (address, read and write strobes)
// and external pads that resolve drive, output enable and pull-up.
`timescale 1ns/10ps
module gsw_gpio_top
    import gsw_pkg::*;
#(
    parameter int NPORT = 4,
    parameter int SETTLE_CYC = GSW_SETTLE_CYC
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // processor i/o space
    input wire logic [7:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic i_io_rd,
    input wire logic [7:0] i_io_wdata,
    output logic [7:0] o_io_rdata,
    // pads
    input wire logic [8*NPORT-1:0] i_pin_in,
    output logic [8*NPORT-1:0] o_pin_out,
    output logic [8*NPORT-1:0] o_pin_oe_n,
    output logic [8*NPORT-1:0] o_pin_pullup,
    // parallel host mode read path
    input wire logic [NPORT-1:0] i_phm_en,
    input wire logic [8*NPORT-1:0] i_phm_latch,
    // core status and interrupt
    input wire logic i_irq_sense,
    input wire logic i_irq_ack,
    input wire logic i_instr_done,
    output logic o_gpio_irq,
    // suspend and wake
    input wire logic i_usb_activity,
    input wire logic i_osc_stable,
    output logic o_suspended,
    output logic o_osc_en,
    output logic o_ready
);

    localparam int NPIN = 8 * NPORT;

    // registers
    logic [7:0] pdata_reg [NPORT];
    logic [7:0] pie_reg [NPORT];
    logic [7:0] cfg_reg;
    logic [7:0] gie_reg;
    logic run_reg;
    logic [NPIN-1:0] pend_reg;
    logic [7:0] rdata_reg;
    logic [NPIN-1:0] out_reg;
    logic [NPIN-1:0] oe_n_reg;
    logic [NPIN-1:0] pull_reg;
    logic irq_reg;
    logic susp_reg;
    logic osc_reg;
    logic ready_reg;

    // combinational
    logic [NPIN-1:0] level;
    logic [NPIN-1:0] rise;
    logic [NPIN-1:0] fall;
    logic [NPIN-1:0] hit;
    logic [NPIN-1:0] out_next;
    logic [NPIN-1:0] oe_n_next;
    logic [NPIN-1:0] pull_next;
    logic [7:0] rdata_next;
    logic gpio_en;
    logic running;
    logic wr_ok;
    logic suspend_req;
    logic wake;
    logic defer;
    gsw_wake_t wake_state;

    gsw_pin_sync #(
        .W(NPIN)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_pin(i_pin_in),
        .o_level(level),
        .o_rise(rise),
        .o_fall(fall)
    );

    assign running = (wake_state == GSW_ST_RUN);
    // register writes are part of the logic that stops in suspend
    assign wr_ok = i_io_wr && running;
    assign gpio_en = gie_reg[GSW_GIE_GPIO_BIT];
    assign suspend_req = wr_ok && (i_io_addr == GSW_OFF_PSC)
        && i_io_wdata[GSW_PSC_SUSP_BIT];

    // per-pin drive and edge qualification
    for (genvar p = 0; p < NPIN; p++) begin : g_pin
        localparam int PORT = p / 8;
        logic [1:0] cfg;
        logic d;
        assign cfg = cfg_reg[2*PORT +: 2];
        assign d = pdata_reg[PORT][p % 8];

        always_comb begin
            out_next[p] = 1'b0;
            oe_n_next[p] = 1'b1;
            pull_next[p] = 1'b0;
            if (!d) begin
                oe_n_next[p] = 1'b0;
            end else if (cfg == GSW_CFG_CMOS) begin
                out_next[p] = 1'b1;
                oe_n_next[p] = 1'b0;
            end else if (cfg == GSW_CFG_RESIST) begin
                pull_next[p] = 1'b1;
            end
        end

        // data one and a non push-pull port arm the pin; polarity is
        // rising only for the plain open-drain code
        always_comb begin
            hit[p] = 1'b0;
            if (d && cfg != GSW_CFG_CMOS && pie_reg[PORT][p % 8]) begin
                if (cfg == GSW_CFG_OD_RISE) begin
                    hit[p] = rise[p];
                end else begin
                    hit[p] = fall[p];
                end
            end
        end
    end

    // wake on an enabled pin event or usb traffic
    assign wake = i_usb_activity
        || ((|hit) && gpio_en && i_irq_sense);

    gsw_wake_ctl #(
        .SETTLE_CYC(SETTLE_CYC)
    ) u_wake (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_suspend_req(suspend_req),
        .i_run_bit(run_reg),
        .i_wake(wake),
        .i_osc_stable(i_osc_stable),
        .i_instr_done(i_instr_done),
        .o_state(wake_state),
        .o_defer(defer)
    );

    // port data and enables
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int n = 0; n < NPORT; n++) begin
                pdata_reg[n] <= GSW_PDATA_RST;
                pie_reg[n] <= GSW_PIE_RST;
            end
        end else if (wr_ok) begin
            for (int n = 0; n < NPORT; n++) begin
                if (i_io_addr == GSW_OFF_PDATA0 + 8'(n)) begin
                    pdata_reg[n] <= i_io_wdata;
                end
                if (i_io_addr == GSW_OFF_PIE0 + 8'(n)) begin
                    pie_reg[n] <= i_io_wdata;
                end
            end
        end
    end

    // port configuration
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_reg <= GSW_CFG_RST;
        end else if (wr_ok && i_io_addr == GSW_OFF_CFG) begin
            cfg_reg <= i_io_wdata;
        end
    end

    // global enables and run bit
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gie_reg <= GSW_GIE_RST;
            run_reg <= GSW_RUN_RST[0];
        end else if (wr_ok) begin
            if (i_io_addr == GSW_OFF_GIE) begin
                gie_reg <= i_io_wdata;
            end
            if (i_io_addr == GSW_OFF_PSC) begin
                run_reg <= i_io_wdata[GSW_PSC_RUN_BIT];
            end
        end
    end

    // pending edges; a new edge wins over a service clear. the pin
    // logic keeps running in suspend so the wake edge is kept too
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_reg <= '0;
        end else if (i_irq_ack) begin
            pend_reg <= hit;
        end else begin
            pend_reg <= pend_reg | hit;
        end
    end

    // interrupt line, held off while waking and until the first
    // instruction after wake has retired
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (|pend_reg) && gpio_en && i_irq_sense
                && running && !defer;
        end
    end

    // read path
    always_comb begin
        rdata_next = GSW_RD_UNMAPPED;
        for (int n = 0; n < NPORT; n++) begin
            if (i_io_addr == GSW_OFF_PDATA0 + 8'(n)) begin
                if (i_phm_en[n]) begin
                    rdata_next = i_phm_latch[8*n +: 8];
                end else begin
                    rdata_next = level[8*n +: 8];
                end
            end
            if (i_io_addr == GSW_OFF_PIE0 + 8'(n)) begin
                rdata_next = pie_reg[n];
            end
        end
        if (i_io_addr == GSW_OFF_CFG) begin
            rdata_next = cfg_reg;
        end
        if (i_io_addr == GSW_OFF_GIE) begin
            rdata_next = gie_reg;
        end
        if (i_io_addr == GSW_OFF_PSC) begin
            rdata_next = GSW_RD_UNMAPPED;
            rdata_next[GSW_PSC_RUN_BIT] = run_reg;
            rdata_next[GSW_PSC_SENSE_BIT] = i_irq_sense;
            rdata_next[GSW_PSC_SUSP_BIT] = !running;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_reg <= GSW_RD_UNMAPPED;
        end else if (i_io_rd && running) begin
            rdata_reg <= rdata_next;
        end
    end

    // pad drive, registered so the pads see no decode glitches
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_reg <= '0;
            oe_n_reg <= '1;
            pull_reg <= '0;
        end else begin
            out_reg <= out_next;
            oe_n_reg <= oe_n_next;
            pull_reg <= pull_next;
        end
    end

    // power state
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            susp_reg <= 1'b0;
            osc_reg <= 1'b1;
            ready_reg <= 1'b1;
        end else begin
            susp_reg <= (wake_state == GSW_ST_SUSP);
            osc_reg <= (wake_state != GSW_ST_SUSP);
            ready_reg <= running;
        end
    end

    assign o_io_rdata = rdata_reg;
    assign o_pin_out = out_reg;
    assign o_pin_oe_n = oe_n_reg;
    assign o_pin_pullup = pull_reg;
    assign o_gpio_irq = irq_reg;
    assign o_suspended = susp_reg;
    assign o_osc_en = osc_reg;
    assign o_ready = ready_reg;

endmodule

// file: gsw_pkg.sv
// constants shared by the port block: register map, field layout,
// reset values, drive encodings and wake timing.
// assumes a 100 MHz system clock and an 8-bit processor i/o space.
package gsw_pkg;

    // i/o space offsets; port n data sits at data base + n
    localparam logic [7:0] GSW_OFF_PDATA0 = 8'h00;
    localparam logic [7:0] GSW_OFF_PDATA3 = 8'h03;
    localparam logic [7:0] GSW_OFF_PIE0 = 8'h04;
    localparam logic [7:0] GSW_OFF_CFG = 8'h08;
    localparam logic [7:0] GSW_OFF_GIE = 8'h20;
    localparam logic [7:0] GSW_OFF_PSC = 8'hff;

    // field positions
    localparam int GSW_GIE_GPIO_BIT = 6;
    localparam int GSW_PSC_RUN_BIT = 0;
    localparam int GSW_PSC_SENSE_BIT = 2;
    localparam int GSW_PSC_SUSP_BIT = 3;

    // values after reset
    localparam logic [7:0] GSW_PDATA_RST = 8'hff;
    localparam logic [7:0] GSW_CFG_RST = 8'h00;
    localparam logic [7:0] GSW_PIE_RST = 8'h00;
    localparam logic [7:0] GSW_GIE_RST = 8'h00;
    localparam logic [7:0] GSW_RUN_RST = 8'h01;
    localparam logic [7:0] GSW_RD_UNMAPPED = 8'h00;

    // per-port drive configuration codes
    localparam logic [1:0] GSW_CFG_OD_RISE = 2'h0;
    localparam logic [1:0] GSW_CFG_OD_FALL = 2'h1;
    localparam logic [1:0] GSW_CFG_CMOS = 2'h2;
    localparam logic [1:0] GSW_CFG_RESIST = 2'h3;

    // wake settle time after the oscillator is stable
    localparam int GSW_CLK_PERIOD_NS = 10;
    localparam int GSW_T_SETTLE_NS = 1000000;
    localparam int GSW_SETTLE_CYC = GSW_T_SETTLE_NS / GSW_CLK_PERIOD_NS;

    // suspend / wake sequence, gray coded along the usual path
    typedef enum logic [1:0] {
        GSW_ST_RUN = 2'h0,
        GSW_ST_SUSP = 2'h1,
        GSW_ST_OSC = 2'h3,
        GSW_ST_SETTLE = 2'h2
    } gsw_wake_t;

endpackage

// file: gsw_pin_sync.sv
// two-stage synchroniser and edge detector for a bank of pins.
// assumes pin levels may change at any time relative to the clock.
`timescale 1ns/10ps
module gsw_pin_sync #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // raw pins in
    input wire logic [W-1:0] i_pin,
    // synchronised level and edges
    output logic [W-1:0] o_level,
    output logic [W-1:0] o_rise,
    output logic [W-1:0] o_fall
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;

    // reset to ones: pins float high through the reset state
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= '1;
            sync_reg <= '1;
            prev_reg <= '1;
        end else begin
            meta_reg <= i_pin;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign o_level = sync_reg;
    assign o_rise = sync_reg & ~prev_reg;
    assign o_fall = ~sync_reg & prev_reg;

endmodule

// file: gsw_wake_ctl.sv
// suspend and wake sequencer: holds the part stopped until a wake
// event, restarts the oscillator, waits the settle time, then holds
// interrupts off until the first instruction after wake has retired.
// assumes the core reports retirement with a one-cycle pulse.
`timescale 1ns/10ps
module gsw_wake_ctl
    import gsw_pkg::*;
#(
    parameter int SETTLE_CYC = GSW_SETTLE_CYC
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // requests and events
    input wire logic i_suspend_req,
    input wire logic i_run_bit,
    input wire logic i_wake,
    input wire logic i_osc_stable,
    input wire logic i_instr_done,
    // state
    output gsw_wake_t o_state,
    output logic o_defer
);

    gsw_wake_t state_reg;
    logic [$clog2(SETTLE_CYC+1)-1:0] cnt_reg;
    logic defer_reg;
    logic settle_done;

    assign settle_done = (cnt_reg == ($bits(cnt_reg))'(SETTLE_CYC - 1));

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= GSW_ST_RUN;
        end else begin
            unique case (state_reg)
                GSW_ST_RUN: begin
                    if (i_suspend_req) begin
                        state_reg <= GSW_ST_SUSP;
                    end
                end
                GSW_ST_SUSP: begin
                    // without the run bit the part never resumes
                    if (i_wake && i_run_bit) begin
                        state_reg <= GSW_ST_OSC;
                    end
                end
                GSW_ST_OSC: begin
                    if (i_osc_stable) begin
                        state_reg <= GSW_ST_SETTLE;
                    end
                end
                GSW_ST_SETTLE: begin
                    if (settle_done) begin
                        state_reg <= GSW_ST_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= '0;
        end else if (state_reg == GSW_ST_SETTLE) begin
            cnt_reg <= cnt_reg + 1'b1;
        end else begin
            cnt_reg <= '0;
        end
    end

    // interrupts wait for the first instruction retired after wake
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            defer_reg <= 1'b0;
        end else if (state_reg == GSW_ST_SETTLE && settle_done) begin
            defer_reg <= 1'b1;
        end else if (state_reg == GSW_ST_RUN && i_instr_done) begin
            defer_reg <= 1'b0;
        end
    end

    assign o_state = state_reg;
    assign o_defer = defer_reg;

endmodule

// file: gsw_gpio_checker.sv
// concurrent checks on pad drive, pin interrupt and wake outputs.
// assumes one clock domain; bound to the top module below.
`timescale 1ns/10ps
module gsw_gpio_checker
    import gsw_pkg::*;
#(
    parameter int NPORT = 4,
    parameter int SETTLE_CYC = GSW_SETTLE_CYC
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // i/o space
    input wire logic [7:0] i_io_addr,
    input wire logic i_io_wr,
    input wire logic [7:0] i_io_wdata,
    // pads
    input wire logic [8*NPORT-1:0] i_pin_in,
    input wire logic [8*NPORT-1:0] o_pin_oe_n,
    input wire logic [8*NPORT-1:0] o_pin_pullup,
    // interrupt
    input wire logic i_irq_sense,
    input wire logic i_irq_ack,
    input wire logic o_gpio_irq,
    // suspend and wake
    input wire logic i_usb_activity,
    input wire logic i_osc_stable,
    input wire logic o_suspended,
    input wire logic o_osc_en,
    input wire logic o_ready
);
    logic [31:0] settle_cnt_reg;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    // cycles spent waking with a stable oscillator, cleared once ready
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            settle_cnt_reg <= 32'h0;
        end else if (o_ready) begin
            settle_cnt_reg <= 32'h0;
        end else if (!o_suspended && i_osc_stable) begin
            settle_cnt_reg <= settle_cnt_reg + 32'h1;
        end
    end

    sequence quiet_two_s;
        !o_gpio_irq ##1 !o_gpio_irq;
    endsequence
    sequence usb_wake_s;
        o_suspended && i_usb_activity;
    endsequence
    sequence susp_write_s;
        i_io_wr && o_ready && i_io_addr == GSW_OFF_PSC
            && i_io_wdata[GSW_PSC_SUSP_BIT];
    endsequence

    pullup_excl_a: assert property (
        (~o_pin_oe_n & o_pin_pullup) == '0)
        else $error("pull-up on while pad driven");
    reset_hiz_a: assert property ($rose(i_rst_n) |-> &o_pin_oe_n)
        else $error("pad driven right after reset");
    irq_sense_a: assert property ($rose(o_gpio_irq) |-> $past(i_irq_sense))
        else $error("irq raised without sense bit");
    ack_clear_a: assert property (i_irq_ack |-> ##2 !o_gpio_irq)
        else $error("irq not cleared by ack");
    // the line is registered, so an ack or a write one cycle back still
    // lowers it on the next edge
    irq_hold_a: assert property (o_gpio_irq && !i_irq_ack && i_irq_sense
        && !i_io_wr && !$past(i_irq_ack) && !$past(i_io_wr)
        |=> o_gpio_irq) else $error("pending irq lost");
    osc_susp_a: assert property (o_osc_en != o_suspended)
        else $error("oscillator enable disagrees with suspend");
    wake_osc_a: assert property (usb_wake_s |-> ##[1:4] o_osc_en)
        else $error("usb activity did not restart oscillator");
    susp_enter_a: assert property (susp_write_s |-> ##[1:3] o_suspended)
        else $error("suspend write not taken");
    settle_min_a: assert property ($rose(o_ready) |-> settle_cnt_reg >= SETTLE_CYC)
        else $error("ready before settle time");
    settle_max_a: assert property (settle_cnt_reg <= SETTLE_CYC + 4)
        else $error("ready late after settle time");
    defer_start_a: assert property ($rose(o_ready) |-> quiet_two_s)
        else $error("irq served before first instruction");
endmodule

bind gsw_gpio_top gsw_gpio_checker #(.NPORT(NPORT), .SETTLE_CYC(SETTLE_CYC))
    gsw_gpio_checker_inst (.i_clk_sys, .i_rst_n, .i_io_addr, .i_io_wr,
    .i_io_wdata, .i_pin_in, .o_pin_oe_n, .o_pin_pullup, .i_irq_sense,
    .i_irq_ack, .o_gpio_irq, .i_usb_activity, .i_osc_stable, .o_suspended,
    .o_osc_en, .o_ready);

// file: gsw_pad_model.sv
// pad model: resolves each pin from the block's drive and pull-up and
// an external source; assumes the block wins whenever it drives.
`timescale 1ns/10ps
module gsw_pad_model (
    // clock
    input wire logic i_clk_sys,
    // block side
    input wire logic [31:0] i_pin_out,
    input wire logic [31:0] i_pin_oe_n,
    input wire logic [31:0] i_pin_pullup,
    // external sources
    input wire logic [31:0] i_ext_en,
    input wire logic [31:0] i_ext_val,
    // resolved pads
    output logic [31:0] o_pin
);
    logic [31:0] float_reg = 32'h0;

    // an undriven pad wanders, so no read of it may look settled
    always_ff @(posedge i_clk_sys) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int b = 0; b < 32; b++) begin
            if (!i_pin_oe_n[b]) begin
                o_pin[b] = i_pin_out[b];
            end else if (i_ext_en[b]) begin
                o_pin[b] = i_ext_val[b];
            end else if (i_pin_pullup[b]) begin
                o_pin[b] = 1'b1;
            end else begin
                o_pin[b] = float_reg[b];
            end
        end
    end
endmodule

// file: gsw_gpio_tb.sv
// self-checking bench for the port block through its i/o space.
// assumes the pad model above stands on the pins.
`timescale 1ns/10ps
module gsw_gpio_tb;
    import gsw_pkg::*;
    localparam int SETTLE = 20;
    logic i_clk_sys = 1'b0, i_rst_n = 1'b0;
    logic [7:0] i_io_addr = 8'h00, i_io_wdata = 8'h00, o_io_rdata, d;
    logic i_io_wr = 1'b0, i_io_rd = 1'b0, i_irq_sense = 1'b0;
    logic i_irq_ack = 1'b0, i_instr_done = 1'b0, i_usb_activity = 1'b0;
    logic i_osc_stable = 1'b1, o_gpio_irq, o_suspended, o_osc_en, o_ready;
    logic [31:0] i_pin_in, o_pin_out, o_pin_oe_n, o_pin_pullup;
    logic [31:0] ext_en = 32'hff00ffff, ext_val = 32'hc3003ca5;
    logic [3:0] i_phm_en = 4'h0;
    logic [31:0] i_phm_latch = 32'h00960000;
    logic [1:0] c;
    logic [7:0] rd_exp [4] = '{8'ha5, 8'h00, 8'h96, 8'hc3};
    logic [1:0] icfg [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
    logic istart [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic iexp [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    int failures = 0, cmp_count = 0, cyc = 0, n;

    gsw_gpio_top #(.NPORT(4), .SETTLE_CYC(SETTLE)) gsw_gpio_top_inst (
        .i_clk_sys, .i_rst_n, .i_io_addr, .i_io_wr, .i_io_rd, .i_io_wdata,
        .o_io_rdata, .i_pin_in, .o_pin_out, .o_pin_oe_n, .o_pin_pullup,
        .i_phm_en, .i_phm_latch, .i_irq_sense, .i_irq_ack, .i_instr_done,
        .o_gpio_irq, .i_usb_activity, .i_osc_stable, .o_suspended,
        .o_osc_en, .o_ready);
    gsw_pad_model gsw_pad_model_inst (.i_clk_sys, .i_pin_out(o_pin_out),
        .i_pin_oe_n(o_pin_oe_n), .i_pin_pullup(o_pin_pullup),
        .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(i_pin_in));

    initial begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    task automatic finish_test();
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // run is about 340 cycles; some fourteen times that means a hang
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge i_clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge i_clk_sys);
        i_io_addr = a;
        i_io_wdata = v;
        i_io_wr = 1'b1;
        @(negedge i_clk_sys);
        i_io_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge i_clk_sys);
        i_io_addr = a;
        i_io_rd = 1'b1;
        @(negedge i_clk_sys);
        i_io_rd = 1'b0;
        @(negedge i_clk_sys);
        v = o_io_rdata;
    endtask
    task automatic pulse(ref logic s);
        @(negedge i_clk_sys);
        s = 1'b1;
        @(negedge i_clk_sys);
        s = 1'b0;
    endtask

    initial begin
        tick(6);
        i_rst_n = 1'b1;
        chk(o_pin_oe_n, 32'hffffffff);
        rd(GSW_OFF_CFG, d);
        chk(d, 8'h00);
        rd(8'h40, d);
        chk(d, 8'h00);
        for (int k = 0; k < 4; k++) wr(8'(k), 8'h5a);
        for (int m = 0; m < 4; m++) begin
            wr(GSW_OFF_CFG, {2'(m + 3), 2'(m + 2), 2'(m + 1), 2'(m)});
            tick(2);
            for (int p = 0; p < 4; p++) begin
                c = 2'(m + p);
                chk(o_pin_out[8*p+:8], c == 2'h2 ? 8'h5a : 8'h00);
                chk(o_pin_oe_n[8*p+:8], c == 2'h2 ? 8'h00 : 8'h5a);
                chk(o_pin_pullup[8*p+:8], c == 2'h3 ? 8'h5a : 8'h00);
            end
        end
        wr(GSW_OFF_CFG, 8'h00);
        // port 1 bits held low; port 2 is left undriven and floats; it is read through the host latch
        for (int k = 0; k < 4; k++) wr(8'(k), k == 1 ? 8'h00 : 8'hff);
        i_phm_en = 4'b0100;
        tick(4);
        for (int k = 0; k < 4; k++) begin
            rd(8'(k), d);
            chk(d, rd_exp[k]);
        end
        i_phm_en = 4'h0;
        wr(GSW_OFF_GIE, 8'h40);
        wr(GSW_OFF_PIE0, 8'h01);
        i_irq_sense = 1'b1;
        for (int k = 0; k < 5; k++) begin
            wr(GSW_OFF_CFG, {6'h00, icfg[k]});
            ext_val[0] = istart[k];
            tick(5);
            pulse(i_irq_ack);
            tick(3);
            ext_val[0] = ~istart[k];
            tick(6);
            chk(o_gpio_irq, iexp[k]);
            tick(10);
            chk(o_gpio_irq, iexp[k]);
            pulse(i_irq_ack);
            tick(2);
            chk(o_gpio_irq, 1'b0);
        end
        i_irq_sense = 1'b0;
        ext_val[0] = 1'b1;
        tick(6);
        chk(o_gpio_irq, 1'b0);
        i_irq_sense = 1'b1;
        tick(3);
        chk(o_gpio_irq, 1'b1);
        pulse(i_irq_ack);
        ext_val[0] = 1'b0;
        i_osc_stable = 1'b0;
        tick(5);
        wr(GSW_OFF_PSC, 8'h09);
        tick(3);
        chk({o_suspended, o_osc_en, o_ready}, 3'b100);
        wr(GSW_OFF_CFG, 8'hff);
        tick(10);
        chk(o_suspended, 1'b1);
        ext_val[0] = 1'b1;
        tick(6);
        chk({o_suspended, o_osc_en, o_ready}, 3'b010);
        i_osc_stable = 1'b1;
        n = 0;
        while (o_ready !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        chk(n >= SETTLE && n <= SETTLE + 4, 1'b1);
        tick(3);
        chk(o_gpio_irq, 1'b0);
        pulse(i_instr_done);
        tick(3);
        chk(o_gpio_irq, 1'b1);
        pulse(i_irq_ack);
        rd(GSW_OFF_CFG, d);
        chk(d, 8'h00);
        rd(GSW_OFF_PIE0, d);
        chk(d, 8'h01);
        rd(GSW_OFF_PSC, d);
        chk(d, 8'h05);
        i_osc_stable = 1'b0;
        wr(GSW_OFF_PSC, 8'h09);
        tick(4);
        i_usb_activity = 1'b1;
        tick(3);
        i_usb_activity = 1'b0;
        i_osc_stable = 1'b1;
        tick(SETTLE + 6);
        chk(o_ready, 1'b1);
        finish_test();
    end
endmodule
